// [design/psc_control_port.sv]
// Control port of a four-bit digital phase shifter: serial and parallel
// control inputs, daisy-chain output and an AHB-Lite register window.
// Assumes all control pins are asynchronous to clock and the serial clock
// runs well below a quarter of the system clock rate.
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module psc_control_port #(
  parameter int LOAD_CNT_W = 16
) (
  // Clock and reset
  input  wire logic                              clock,
  input  wire logic                              rstn,
  // AHB-Lite slave
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic                                   hreadyout,
  output logic      [31:0]                       hrdata,
  output logic                                   hresp,
  // Mode select: high for serial, low for parallel
  input  wire logic                              mode_select,
  // Dedicated parallel bits
  input  wire logic                              phase_bit_180,
  input  wire logic                              phase_bit_90,
  input  wire logic                              phase_bit_45,
  // Shared pins: strobe or 22.5 bit, shift clock or spare b, data in or spare a
  input  wire logic                              load_strobe,
  input  wire logic                              shift_clock,
  input  wire logic                              shift_data_in_line,
  // Daisy-chain output and phase state
  output logic                                   shift_data_out_line,
  output logic      [psc_pkg::PHASE_BITS-1:0]    phase_state
);

  logic [psc_pkg::PIN_N-1:0]      pin_raw;
  logic [psc_pkg::PIN_N-1:0]      pin_lvl;
  logic [psc_pkg::PIN_N-1:0]      pin_rise;
  logic                           serial_mode;
  logic                           strobe_lvl;
  logic                           shift_en;
  logic                           strobe_event;
  logic                           load_take;
  logic                           short_set;
  logic                           space_set;
  logic [psc_pkg::PHASE_BITS-1:0] par_word;

  logic [psc_pkg::WORD_BITS-1:0]  shreg_r;
  logic [psc_pkg::CNT_W-1:0]      bit_cnt_r;
  logic                           sdo_r;
  logic [psc_pkg::PHASE_BITS-1:0] phase_r;
  logic [psc_pkg::GAP_W-1:0]      gap_r;
  logic                           space_err_r;
  logic                           short_err_r;
  logic [LOAD_CNT_W-1:0]          loads_r;
  logic                           hold_r;
  logic [11:0]                    angle_r;

  logic                           addr_phase;
  logic                           wr_pend_r;
  logic [31:0]                    wr_addr_r;
  logic                           wr_ctrl;
  logic                           wr_status;
  logic                           wr_loads;
  logic [31:0]                    rd_mux;
  logic [31:0]                    hrdata_r;
  logic                           hreadyout_r;
  logic                           hresp_r;

  // Pin synchronisation; the shared pins are decoded by mode afterwards
  assign pin_raw[psc_pkg::PIN_MODE]   = mode_select;
  assign pin_raw[psc_pkg::PIN_STROBE] = load_strobe;
  assign pin_raw[psc_pkg::PIN_SCLK]   = shift_clock;
  assign pin_raw[psc_pkg::PIN_SDI]    = shift_data_in_line;
  assign pin_raw[psc_pkg::PIN_B45]    = phase_bit_45;
  assign pin_raw[psc_pkg::PIN_B90]    = phase_bit_90;
  assign pin_raw[psc_pkg::PIN_B180]   = phase_bit_180;

  psc_sync #(
    .WIDTH  (psc_pkg::PIN_N)
  ) u_sync (
    .clock  (clock),
    .rstn   (rstn),
    .raw_in (pin_raw),
    .level  (pin_lvl),
    .rise   (pin_rise)
  );

  assign serial_mode  = pin_lvl[psc_pkg::PIN_MODE];
  assign strobe_lvl   = serial_mode & pin_lvl[psc_pkg::PIN_STROBE];
  assign shift_en     = serial_mode & pin_rise[psc_pkg::PIN_SCLK] & ~strobe_lvl;
  assign strobe_event = serial_mode & pin_rise[psc_pkg::PIN_STROBE];
  assign load_take    = strobe_event & (bit_cnt_r == psc_pkg::WORD_FULL);
  assign short_set    = strobe_event & (bit_cnt_r != psc_pkg::WORD_FULL);
  assign space_set    = strobe_event &
                        (gap_r < psc_pkg::GAP_W'(psc_pkg::LES_CYC - 1));

  // Parallel word: spare bits on the shared clock and data pins are dropped
  assign par_word = {pin_lvl[psc_pkg::PIN_B180],
                     pin_lvl[psc_pkg::PIN_B90],
                     pin_lvl[psc_pkg::PIN_B45],
                     pin_lvl[psc_pkg::PIN_STROBE]};

  // Shift register moves one place toward the top on each taken clock edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      shreg_r <= psc_pkg::RST_SHIFT;
    end else if (shift_en) begin
      shreg_r <= {shreg_r[psc_pkg::WORD_BITS-2:0],
                  pin_lvl[psc_pkg::PIN_SDI]};
    end
  end

  // Daisy-chain output: the bit pushed out of the top, parked low in parallel
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sdo_r <= 1'b0;
    end else if (!serial_mode) begin
      sdo_r <= 1'b0;
    end else if (shift_en) begin
      sdo_r <= shreg_r[psc_pkg::WORD_BITS-1];
    end
  end

  // Bits shifted since the last strobe, saturating at a full word
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bit_cnt_r <= '0;
    end else if (shift_en) begin
      if (bit_cnt_r != psc_pkg::WORD_FULL) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end else if (strobe_event) begin
      bit_cnt_r <= '0;
    end
  end

  // Phase state: frozen while hold is set; else parallel follows the pins, serial updates only on a taken strobe
  always_ff @(posedge clock) begin
    if (!rstn) begin
      phase_r <= psc_pkg::RST_PHASE;
    end else if (hold_r) begin
      phase_r <= phase_r;
    end else if (!serial_mode) begin
      phase_r <= par_word;
    end else if (load_take) begin
      phase_r <= shreg_r[psc_pkg::WORD_BITS-1 -: psc_pkg::PHASE_BITS];
    end else begin
      phase_r <= phase_r;
    end
  end

  // Phase angle in tenths of a degree, binary weighted from the state
  always_ff @(posedge clock) begin
    if (!rstn) begin
      angle_r <= '0;
    end else begin
      angle_r <= 12'({8'h00, phase_r} * psc_pkg::STEP_TENTHS);
    end
  end

  // Cycles since the last strobe, saturating at the minimum spacing
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gap_r <= psc_pkg::GAP_W'(psc_pkg::LES_CYC);
    end else if (strobe_event) begin
      gap_r <= '0;
    end else if (gap_r < psc_pkg::GAP_W'(psc_pkg::LES_CYC)) begin
      gap_r <= gap_r + 6'h01;
    end
  end

  // Spacing error, write one to clear; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      space_err_r <= 1'b0;
    end else begin
      space_err_r <= space_set |
                     (space_err_r & ~(wr_status & hwdata[psc_pkg::STAT_SPACE_ERR]));
    end
  end

  // Short word error, write one to clear; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      short_err_r <= 1'b0;
    end else begin
      short_err_r <= short_set |
                     (short_err_r & ~(wr_status & hwdata[psc_pkg::STAT_SHORT_ERR]));
    end
  end

  // Taken load counter, cleared by any write to the loads register; a load in that cycle counts
  always_ff @(posedge clock) begin
    if (!rstn) begin
      loads_r <= '0;
    end else if (wr_loads) begin
      loads_r <= load_take ? LOAD_CNT_W'(1) : '0;
    end else if (load_take) begin
      loads_r <= loads_r + LOAD_CNT_W'(1);
    end
  end

  // Control register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hold_r <= 1'b0;
    end else if (wr_ctrl) begin
      hold_r <= hwdata[psc_pkg::CTRL_HOLD];
    end
  end

  // AHB-Lite address phase capture; only word transfers are expected
  assign addr_phase = hsel & hready & htrans[1];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_r <= haddr;
      end
    end
  end

  assign wr_ctrl   = wr_pend_r & (wr_addr_r == psc_pkg::OFS_CTRL);
  assign wr_status = wr_pend_r & (wr_addr_r == psc_pkg::OFS_STATUS);
  assign wr_loads  = wr_pend_r & (wr_addr_r == psc_pkg::OFS_LOADS);

  // Read data selection; unmapped addresses read as zero
  always_comb begin
    rd_mux = '0;
    unique case (haddr)
      psc_pkg::OFS_CTRL: begin
        rd_mux[psc_pkg::CTRL_HOLD] = hold_r;
      end
      psc_pkg::OFS_STATUS: begin
        rd_mux[psc_pkg::STAT_PHASE_LSB +: psc_pkg::PHASE_BITS] = phase_r;
        rd_mux[psc_pkg::STAT_SERIAL]    = serial_mode;
        rd_mux[psc_pkg::STAT_SPACE_ERR] = space_err_r;
        rd_mux[psc_pkg::STAT_SHORT_ERR] = short_err_r;
        rd_mux[psc_pkg::STAT_STROBE]    = strobe_lvl;
        rd_mux[psc_pkg::STAT_HOLD]      = hold_r;
      end
      psc_pkg::OFS_SHIFT: begin
        rd_mux[psc_pkg::WORD_BITS-1:0] = shreg_r;
        rd_mux[psc_pkg::SHIFT_CNT_LSB +: psc_pkg::CNT_W] = bit_cnt_r;
      end
      psc_pkg::OFS_LOADS: begin
        rd_mux[LOAD_CNT_W-1:0] = loads_r;
      end
      psc_pkg::OFS_PINS: begin
        rd_mux[psc_pkg::PIN_N-1:0] = pin_lvl;
      end
      psc_pkg::OFS_ANGLE: begin
        rd_mux[11:0] = angle_r;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Zero wait state slave, always OKAY
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hrdata_r    <= '0;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hrdata_r    <= (addr_phase & ~hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  assign hrdata              = hrdata_r;
  assign hreadyout           = hreadyout_r;
  assign hresp               = hresp_r;
  assign shift_data_out_line = sdo_r;
  assign phase_state         = phase_r;

endmodule // psc_control_port

// [inc/psc_pkg.sv]
// Constants shared by the phase shifter control port and its helpers.
// Assumes a 50 MHz system clock and a byte-addressed AHB-Lite register window.
package psc_pkg;

  // Serial word layout
  localparam int WORD_BITS  = 6;
  localparam int PHASE_BITS = 4;
  localparam int CNT_W      = 3;
  localparam logic [CNT_W-1:0] WORD_FULL = 3'h6;

  // Synchronised pin bus index
  localparam int PIN_N      = 7;
  localparam int PIN_MODE   = 0;
  localparam int PIN_STROBE = 1;
  localparam int PIN_SCLK   = 2;
  localparam int PIN_SDI    = 3;
  localparam int PIN_B45    = 4;
  localparam int PIN_B90    = 5;
  localparam int PIN_B180   = 6;

  // Register byte offsets
  localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFS_SHIFT  = 32'h0000_0008;
  localparam logic [31:0] OFS_LOADS  = 32'h0000_000c;
  localparam logic [31:0] OFS_PINS   = 32'h0000_0010;
  localparam logic [31:0] OFS_ANGLE  = 32'h0000_0014;

  // Field positions
  localparam int CTRL_HOLD      = 0;
  localparam int STAT_PHASE_LSB = 0;
  localparam int STAT_SERIAL    = 4;
  localparam int STAT_SPACE_ERR = 5;
  localparam int STAT_SHORT_ERR = 6;
  localparam int STAT_STROBE    = 7;
  localparam int STAT_HOLD      = 8;
  localparam int SHIFT_CNT_LSB  = 8;

  // Values after reset
  localparam logic [PHASE_BITS-1:0] RST_PHASE = 4'h0;
  localparam logic [WORD_BITS-1:0]  RST_SHIFT = 6'h00;

  // Phase step in tenths of a degree, lowest weight 22.5 deg
  localparam logic [11:0] STEP_TENTHS = 12'h0e1;

  // AHB
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_LES_NS      = 630;
  localparam int LES_CYC       = (T_LES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W         = 6;

endpackage

// [design/psc_sync.sv]
// Two-flop synchroniser with a third stage for rising edge detection.
// Assumes inputs are asynchronous to clock and held for at least two clock periods.
`timescale 1ns/1ps
module psc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // Asynchronous inputs
  input  wire logic [WIDTH-1:0] raw_in,
  // Synchronised level and rising edge
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;

endmodule // psc_sync

// [test/psc_ctl_model.sv]
// Controller model that drives the control pins of the phase shifter port.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/1ps
module psc_ctl_model (
  // Clock
  input  wire logic clock,
  // Mode and dedicated parallel bits
  output logic      mode_select,
  output logic      phase_bit_180,
  output logic      phase_bit_90,
  output logic      phase_bit_45,
  // Shared pins
  output logic      load_strobe,
  output logic      shift_clock,
  output logic      shift_data_in_line,
  // Daisy-chain return
  input  wire logic shift_data_out_line
);
  initial begin
    mode_select = 1'b1;
    {phase_bit_180, phase_bit_90, phase_bit_45} = 3'h0;
    {load_strobe, shift_clock, shift_data_in_line} = 3'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One 160 ns link clock period; the chained output is sampled before the fall
  task automatic bit_out(input logic b, output logic so);
    shift_data_in_line <= b;
    tick(4);
    shift_clock <= 1'b1;
    tick(4);
    so = shift_data_out_line;
    shift_clock <= 1'b0;
  endtask

  // Word goes out top bit first; the last two are the dummy bits
  task automatic shift_bits(input logic [5:0] w, input int n, output logic [5:0] so);
    for (int i = 5; i > 5 - n; i--) bit_out(w[i], so[i]);
    shift_data_in_line <= ~w[6-n];
  endtask

  // Strobe pulse, optionally with a link clock pulse while it is high
  task automatic strobe(input logic glitch);
    load_strobe <= 1'b1;
    tick(4);
    if (glitch) begin
      shift_clock <= 1'b1;
      tick(4);
      shift_clock <= 1'b0;
      tick(4);
    end
    load_strobe <= 1'b0;
    tick(32);
  endtask

  // Two strobe pulses on purpose closer than the minimum spacing
  task automatic strobe_pair();
    repeat (2) begin
      load_strobe <= 1'b1;
      tick(4);
      load_strobe <= 1'b0;
      tick(4);
    end
    tick(32);
  endtask

  task automatic set_mode(input logic m);
    mode_select <= m;
    tick(6);
  endtask

  // Spare bits stay fixed for each setting
  task automatic par(input logic [5:0] p);
    {phase_bit_180, phase_bit_90, phase_bit_45} <= p[5:3];
    {load_strobe, shift_clock, shift_data_in_line} <= p[2:0];
    tick(6);
  endtask
endmodule // psc_ctl_model

// [test/psc_control_port_properties.sv]
// Concurrent checks on the pins and bus response of the control port.
// Assumes it is bound into psc_control_port; pins change after clock edges.
`timescale 1ns/1ps
module psc_control_port_properties (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Pins
  input wire logic        mode_select,
  input wire logic        phase_bit_180,
  input wire logic        phase_bit_90,
  input wire logic        phase_bit_45,
  input wire logic        load_strobe,
  input wire logic        shift_clock,
  input wire logic        shift_data_out_line,
  input wire logic [3:0]  phase_state
);
  logic [3:0] par_pins;
  assign par_pins = {phase_bit_180, phase_bit_90, phase_bit_45, load_strobe};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_par_quiet;
    (!mode_select && $stable(par_pins))[*5];
  endsequence
  sequence s_serial_idle;
    (mode_select && !load_strobe)[*8];
  endsequence
  sequence s_clock_idle;
    (mode_select && !shift_clock)[*8];
  endsequence

  chk_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or error");
  chk_rd_quiet: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 0)
    else $error("read data outside data phase");
  chk_par_follow: assert property (s_par_quiet |-> phase_state == par_pins)
    else $error("parallel phase mismatch");
  chk_par_sdo: assert property ((!mode_select)[*4] |-> !shift_data_out_line)
    else $error("chain output active in parallel");
  chk_serial_hold: assert property (s_serial_idle |=> $stable(phase_state))
    else $error("phase moved without strobe");
  chk_load_cause: assert property ($changed(phase_state) && mode_select
    && $past(mode_select, 6) |-> $past(load_strobe, 2) && !$past(load_strobe, 5))
    else $error("phase load without strobe edge");
  chk_sdo_cause: assert property ($changed(shift_data_out_line) && mode_select
    && $past(mode_select, 6) |-> $past(shift_clock, 2) && !$past(load_strobe, 3))
    else $error("chain output moved without shift");
  chk_sdo_still: assert property (s_clock_idle |=> $stable(shift_data_out_line))
    else $error("chain output moved while clock idle");
endmodule // psc_control_port_properties

bind psc_control_port psc_control_port_properties u_psc_control_port_properties (
  .clock, .rstn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
  .mode_select, .phase_bit_180, .phase_bit_90, .phase_bit_45, .load_strobe,
  .shift_clock, .shift_data_out_line, .phase_state);

// [test/phase_shifter_control_port_bench.sv]
// Self-checking bench for the phase shifter control port.
// Assumes the controller model drives the pins and the checker is bound in.
`timescale 1ns/1ps
module phase_shifter_control_port_bench;
  logic        clock, rstn, hsel, hwrite, hreadyout, hresp;
  logic        mode_select, phase_bit_180, phase_bit_90, phase_bit_45;
  logic        load_strobe, shift_clock, shift_data_in_line, shift_data_out_line;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  phase_state;
  logic [5:0]  so;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          n_fail, n_compared;

  psc_control_port u_psc_control_port (
    .clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready (hreadyout), .hreadyout, .hrdata, .hresp, .mode_select, .phase_bit_180,
    .phase_bit_90, .phase_bit_45, .load_strobe, .shift_clock, .shift_data_in_line,
    .shift_data_out_line, .phase_state);

  psc_ctl_model u_psc_ctl_model (
    .clock, .mode_select, .phase_bit_180, .phase_bit_90, .phase_bit_45,
    .load_strobe, .shift_clock, .shift_data_in_line, .shift_data_out_line);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic close_out();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_fail++;
        $display("ERROR %0t bus wait timed out", $time);
        close_out();
      end
      @(posedge clock);
    end
  endtask

  // Single word transfer; read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= psc_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic t_reset();
    check(32'(phase_state), 32'h0, "reset phase");
    ahb(1'b0, psc_pkg::OFS_STATUS, 32'h0, rd);
    check(rd, 32'h0000_0010, "status");
    ahb(1'b0, 32'h0000_0018, 32'h0, rd);
    check(rd, 32'h0, "unmapped");
  endtask

  task automatic t_words();
    logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
    foreach (codes[i]) begin
      u_psc_ctl_model.shift_bits({codes[i], 2'(i)}, 6, so);
      u_psc_ctl_model.strobe(1'b0);
      check(32'(phase_state), 32'(codes[i]), "phase");
      ahb(1'b0, psc_pkg::OFS_ANGLE, 32'h0, rd);
      check(rd, 32'(codes[i]) * 32'h0000_00e1, "angle");
    end
    ahb(1'b0, psc_pkg::OFS_LOADS, 32'h0, rd);
    check(rd, 32'h0000_0006, "loads");
  endtask

  task automatic t_daisy();
    u_psc_ctl_model.shift_bits(6'h2d, 6, so);
    u_psc_ctl_model.strobe(1'b0);
    u_psc_ctl_model.shift_bits(6'h16, 6, so);
    check(32'(so), 32'h0000_002d, "chain out");
    check(32'(phase_state), 32'h0000_000b, "held");
    ahb(1'b0, psc_pkg::OFS_SHIFT, 32'h0, rd);
    check(rd, 32'h0000_0616, "shift reg");
    u_psc_ctl_model.strobe(1'b1);
    check(32'(phase_state), 32'h0000_0005, "load");
    ahb(1'b0, psc_pkg::OFS_SHIFT, 32'h0, rd);
    check(rd, 32'h0000_0016, "masked clock");
  endtask

  task automatic t_short();
    u_psc_ctl_model.shift_bits(6'h38, 3, so);
    u_psc_ctl_model.strobe(1'b0);
    check(32'(phase_state), 32'h0000_0005, "short word");
    ahb(1'b0, psc_pkg::OFS_STATUS, 32'h0, rd);
    check(rd, 32'h0000_0055, "short flag");
    ahb(1'b1, psc_pkg::OFS_STATUS, 32'h0000_0040, rd);
    ahb(1'b0, psc_pkg::OFS_STATUS, 32'h0, rd);
    check(rd, 32'h0000_0015, "flag clear");
  endtask

  task automatic t_parallel();
    logic [5:0] pins [7] = '{6'h03, 6'h05, 6'h0a, 6'h12, 6'h21, 6'h3c, 6'h00};
    u_psc_ctl_model.set_mode(1'b0);
    foreach (pins[i]) begin
      u_psc_ctl_model.par(pins[i]);
      check(32'(phase_state), 32'(pins[i][5:2]), "parallel");
      check(32'(shift_data_out_line), 32'h0, "chain parked");
    end
    ahb(1'b0, psc_pkg::OFS_SHIFT, 32'h0, rd);
    check(32'(rd[5:0]), 32'h0000_0037, "shift kept");
    u_psc_ctl_model.set_mode(1'b1);
    u_psc_ctl_model.shift_bits(6'h24, 6, so);
    u_psc_ctl_model.strobe(1'b0);
    check(32'(phase_state), 32'h0000_0009, "serial again");
  endtask

  task automatic t_regs();
    ahb(1'b1, psc_pkg::OFS_CTRL, 32'h0000_0001, rd);
    ahb(1'b0, psc_pkg::OFS_CTRL, 32'h0, rd);
    check(rd, 32'h0000_0001, "hold set");
    u_psc_ctl_model.shift_bits(6'h3c, 6, so);
    u_psc_ctl_model.strobe(1'b0);
    check(32'(phase_state), 32'h0000_0009, "hold keeps phase");
    ahb(1'b0, psc_pkg::OFS_STATUS, 32'h0, rd);
    check(rd, 32'h0000_0119, "hold status");
    ahb(1'b1, psc_pkg::OFS_CTRL, 32'h0, rd);
    ahb(1'b1, psc_pkg::OFS_LOADS, 32'h0, rd);
    ahb(1'b0, psc_pkg::OFS_LOADS, 32'h0, rd);
    check(rd, 32'h0, "loads cleared");
    u_psc_ctl_model.shift_bits(6'h28, 6, so);
    u_psc_ctl_model.strobe_pair();
    check(32'(phase_state), 32'h0000_000a, "close strobes");
    ahb(1'b0, psc_pkg::OFS_STATUS, 32'h0, rd);
    check(rd, 32'h0000_007a, "spacing flag");
    ahb(1'b0, psc_pkg::OFS_LOADS, 32'h0, rd);
    check(rd, 32'h0000_0001, "loads after pair");
    ahb(1'b1, psc_pkg::OFS_STATUS, 32'h0000_0060, rd);
    ahb(1'b0, psc_pkg::OFS_PINS, 32'h0, rd);
    check(rd, 32'h0000_0009, "pins");
    ahb(1'b0, psc_pkg::OFS_STATUS, 32'h0, rd);
    check(rd, 32'h0000_001a, "flags clear");
  endtask

  initial begin
    n_fail = 0;
    n_compared = 0;
    rstn = 1'b0;
    {hsel, hwrite, htrans} = 4'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_words();
    t_daisy();
    t_short();
    t_parallel();
    t_regs();
    close_out();
  end
endmodule // phase_shifter_control_port_bench
